// ### pkg/kpm_pkg.sv
/*
  Shared constants of the keypanel process image block: register offsets,
  byte positions inside the process image, reset values and colour codes.
  Assumes a 32-bit classic Wishbone slave with byte addressing.
*/
package kpm_pkg;

  // Number of keys, LEDs, sensed lines and driven outputs
  localparam int KPM_CHANNELS = 8;

  // Register byte offsets
  localparam logic [7:0] KPM_OFS_INIMG = 8'h00;  // Input image, read only
  localparam logic [7:0] KPM_OFS_OUTIMG = 8'h04;  // Output image, read/write
  localparam logic [7:0] KPM_OFS_COLOUR = 8'h08;  // Decoded colours, read only
  localparam logic [7:0] KPM_OFS_CTRL = 8'h0c;  // Control, read/write

  // Byte positions in the input image word
  localparam int KPM_IN_KEY_BYTE = 0;   // Key states
  localparam int KPM_IN_LINE_BYTE = 1;  // Sensed line levels

  // Byte positions in the output image word
  localparam int KPM_OUT_RED_BYTE = 0;   // Red components
  localparam int KPM_OUT_GRN_BYTE = 1;   // Green components
  localparam int KPM_OUT_BLU_BYTE = 2;   // Blue components
  localparam int KPM_OUT_DOUT_BYTE = 3;  // Digital outputs

  // Control bit positions
  localparam int KPM_CTRL_LAMP_TEST_BIT = 0;  // Force all LEDs white
  localparam int KPM_CTRL_DOUT_OFF_BIT = 1;   // Force all outputs low

  // Reset values
  localparam logic [31:0] KPM_OUTIMG_RST = 32'h0000_0000;
  localparam logic [1:0] KPM_CTRL_RST = 2'h0;
  localparam logic [15:0] KPM_INIMG_RST = 16'h0000;

  // Colour codes reported per LED, three bits each
  localparam logic [2:0] KPM_COL_OFF = 3'h0;
  localparam logic [2:0] KPM_COL_RED = 3'h1;
  localparam logic [2:0] KPM_COL_GREEN = 3'h2;
  localparam logic [2:0] KPM_COL_BLUE = 3'h3;
  localparam logic [2:0] KPM_COL_YELLOW = 3'h4;
  localparam logic [2:0] KPM_COL_WHITE = 3'h5;

endpackage : kpm_pkg

// ### core/kpm_sync.sv
/*
  Two flip-flop level synchroniser for a group of pin inputs.
  Assumes the inputs are quasi-static levels from outside the clock domain;
  no relation between bits of the group is kept across the crossing.
*/
`timescale 1ns/100ps
`default_nettype none

module kpm_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;  // First stage, read only by second stage
  logic [WIDTH-1:0] sync_r;  // Second stage, safe to use

  // Two stages; the first may go metastable and nothing else looks at it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule : kpm_sync

`default_nettype wire

// ### core/kpm_top.sv
/*
  Process image block of an 8-key panel: packs key states and sensed line
  levels into two input bytes, takes red, green, blue and digital output
  bytes from software, decodes each LED colour and drives the outputs.
  Assumes a classic Wishbone master on clk_i, pins that are asynchronous
  levels, and that the controller's image is moved by software over the bus.
*/
// The register offsets and the Wishbone register port are this design's own decisions.
// Notes on behaviour
// RL1: Image ignores every safety channel state
// RL2: Key n goes to input byte 0 bit n
// RL3: Sensed line n goes to byte 1 bit n
// RL4: Red, green, blue come from output bytes 0-2
// RL5: Decode single, yellow, white; others stay dark
// RL6: Controller sets bit x across three bytes
// RL7: Output n follows output byte 3 bit n
`timescale 1ns/100ps
`default_nettype none

module kpm_top
  import kpm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Panel pins
  input wire logic [7:0] key_i,
  input wire logic [7:0] sensed_line_bit_i,
  output logic [7:0] led_red_o,
  output logic [7:0] led_grn_o,
  output logic [7:0] led_blu_o,
  output logic [7:0] dout_o
);

  // Colour decode of one LED from its three component bits
  function automatic logic [2:0] kpm_colour(input logic r, input logic g, input logic b);
    logic [2:0] code;
    code = KPM_COL_OFF;
    case ({r, g, b})
      3'h4: code = KPM_COL_RED;
      3'h2: code = KPM_COL_GREEN;
      3'h1: code = KPM_COL_BLUE;
      3'h6: code = KPM_COL_YELLOW;
      3'h7: code = KPM_COL_WHITE;
      default: code = KPM_COL_OFF;  // Red+blue and green+blue stay dark
    endcase
    return code;
  endfunction : kpm_colour

  // Synchronised pin levels
  logic [15:0] pins_s;     // {lines, keys} after two flops
  logic [7:0] key_s;       // Key states
  logic [7:0] line_s;      // Sensed line levels

  // Process image and control state
  logic [15:0] inimg_r;    // Input image seen by software
  logic [31:0] outimg_r;   // Output image written by software
  logic [1:0] ctrl_r;      // Lamp test and output kill

  // Bus state
  logic ack_r;             // Acknowledge, one cycle per request
  logic [31:0] rdat_r;     // Registered read data

  // LED and output drivers
  logic [7:0] red_r;
  logic [7:0] grn_r;
  logic [7:0] blu_r;
  logic [7:0] dout_r;

  // Decoding wires
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;  // New request, not yet acked
  wire bus_wr = bus_req & wb_we_i;              // Write strobe
  wire hit_inimg = (wb_adr_i[7:2] == KPM_OFS_INIMG[7:2]);
  wire hit_outimg = (wb_adr_i[7:2] == KPM_OFS_OUTIMG[7:2]);
  wire hit_colour = (wb_adr_i[7:2] == KPM_OFS_COLOUR[7:2]);
  wire hit_ctrl = (wb_adr_i[7:2] == KPM_OFS_CTRL[7:2]);
  wire lamp_test = ctrl_r[KPM_CTRL_LAMP_TEST_BIT];
  wire dout_off = ctrl_r[KPM_CTRL_DOUT_OFF_BIT];
  wire [7:0] red_plane = outimg_r[KPM_OUT_RED_BYTE*8 +: 8];
  wire [7:0] grn_plane = outimg_r[KPM_OUT_GRN_BYTE*8 +: 8];
  wire [7:0] blu_plane = outimg_r[KPM_OUT_BLU_BYTE*8 +: 8];
  wire [7:0] dout_plane = outimg_r[KPM_OUT_DOUT_BYTE*8 +: 8];
  wire [23:0] colour_w;    // Three-bit colour code per LED
  wire [7:0] red_nxt;
  wire [7:0] grn_nxt;
  wire [7:0] blu_nxt;
  wire [7:0] dout_nxt;
  wire [31:0] rdat_nxt;

  // Pins cross into the clock domain before anything reads them
  kpm_sync #(
    .WIDTH(16)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({sensed_line_bit_i, key_i}),
    .sync_o(pins_s)
  );

  assign key_s = pins_s[7:0];
  assign line_s = pins_s[15:8];

  // Input image is built from keys and lines only; no safety input exists here
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      inimg_r <= KPM_INIMG_RST;
    end
    else
    begin
      inimg_r[KPM_IN_KEY_BYTE*8 +: 8] <= key_s;    // RL1 RL2
      inimg_r[KPM_IN_LINE_BYTE*8 +: 8] <= line_s;  // RL1 RL3
    end
  end

  // Write strobe of each byte lane of the output image
  wire [3:0] lane_we;  // One strobe per select bit
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      assign lane_we[lane] = bus_wr & hit_outimg & wb_sel_i[lane];  // RL4 RL7
    end
  endgenerate

  // Output image; one process owns the whole word, so no lane has a second
  // driver, and a partial write leaves the other lanes untouched
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      outimg_r <= KPM_OUTIMG_RST;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (lane_we[k])
        begin
          outimg_r[k*8 +: 8] <= wb_dat_i[k*8 +: 8];  // RL4 RL7
        end
      end
    end
  end

  // Control register lives in the low lane
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= KPM_CTRL_RST;
    end
    else if (bus_wr && hit_ctrl && wb_sel_i[0])
    begin
      ctrl_r <= wb_dat_i[1:0];
    end
  end

  // Per-LED colour decode and physical element drive
  genvar led;
  generate
    for (led = 0; led < KPM_CHANNELS; led++)
    begin : g_led
      // Colour is taken from bit led of each of the three planes
      assign colour_w[led*3 +: 3] = kpm_colour(red_plane[led], grn_plane[led],
                                               blu_plane[led]);  // RL4 RL5
      // Yellow lights red and green elements; white lights all three
      assign red_nxt[led] = lamp_test |
                            (colour_w[led*3 +: 3] == KPM_COL_RED) |
                            (colour_w[led*3 +: 3] == KPM_COL_YELLOW) |
                            (colour_w[led*3 +: 3] == KPM_COL_WHITE);  // RL5
      assign grn_nxt[led] = lamp_test |
                            (colour_w[led*3 +: 3] == KPM_COL_GREEN) |
                            (colour_w[led*3 +: 3] == KPM_COL_YELLOW) |
                            (colour_w[led*3 +: 3] == KPM_COL_WHITE);  // RL5
      assign blu_nxt[led] = lamp_test |
                            (colour_w[led*3 +: 3] == KPM_COL_BLUE) |
                            (colour_w[led*3 +: 3] == KPM_COL_WHITE);  // RL5
    end
  endgenerate

  // Kill bit overrides the image so a stuck controller image can be muted
  assign dout_nxt = dout_off ? 8'h00 : dout_plane;  // RL7

  // Output drivers are flops so pins never see decode glitches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      red_r <= 8'h00;
      grn_r <= 8'h00;
      blu_r <= 8'h00;
      dout_r <= 8'h00;
    end
    else
    begin
      red_r <= red_nxt;
      grn_r <= grn_nxt;
      blu_r <= blu_nxt;
      dout_r <= dout_nxt;  // RL7
    end
  end

  // Read selection; unmapped addresses read as zero
  assign rdat_nxt = hit_inimg ? {16'h0000, inimg_r} :
                    hit_outimg ? outimg_r :
                    hit_colour ? {8'h00, colour_w} :
                    hit_ctrl ? {30'h0000_0000, ctrl_r} :
                    32'h0000_0000;

  // Answer every request after one cycle, even unmapped ones, so no master hangs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= bus_req;
      if (bus_req && !wb_we_i)
      begin
        rdat_r <= rdat_nxt;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign led_red_o = red_r;
  assign led_grn_o = grn_r;
  assign led_blu_o = blu_r;
  assign dout_o = dout_r;

  // Checks on the mapping and decode
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Image changes only when keys or lines change
  chk_image_isolated: assert property (  // RL1
    $stable(pins_s) |=> $stable(inimg_r))
    else $error("input image moved without a pin change");

  chk_key_byte: assert property (  // RL2
    ##1 inimg_r[7:0] == $past(key_s))
    else $error("key byte does not follow keys");

  chk_line_byte: assert property (  // RL3
    ##1 inimg_r[15:8] == $past(line_s))
    else $error("line byte does not follow sensed lines");

  // A full write lands; red elements then light for red, yellow and white only,
  // so a red bit paired with blue alone must leave its element dark
  chk_plane_write: assert property (  // RL4
    (bus_wr && hit_outimg && wb_sel_i == 4'hf && !lamp_test)
    |=> (outimg_r == $past(wb_dat_i))
    ##1 (led_red_o == $past(outimg_r[7:0] & (outimg_r[15:8] | ~outimg_r[23:16]))))
    else $error("output image write not reflected on red elements");

  chk_yellow_map: assert property (  // RL5
    (!lamp_test && red_plane[0] && grn_plane[0] && !blu_plane[0])
    |=> (led_red_o[0] && led_grn_o[0] && !led_blu_o[0]))
    else $error("yellow decode wrong");

  chk_dark_pairs: assert property (  // RL5
    (!lamp_test && blu_plane[3] && (red_plane[3] ^ grn_plane[3]))
    |=> !(led_red_o[3] | led_grn_o[3] | led_blu_o[3]))
    else $error("blue pair combination not dark");

  chk_dout_follow: assert property (  // RL7
    !dout_off |=> dout_o == $past(dout_plane))
    else $error("digital outputs do not follow byte 3");

  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  chk_ack_timely: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  // Control bits take the low lane of a write
  chk_ctrl_write: assert property (
    (bus_wr && hit_ctrl && wb_sel_i[0]) |=> (ctrl_r == $past(wb_dat_i[1:0])))
    else $error("control write did not land");

  // Lamp test lights every element whatever the image says
  chk_lamp_lights: assert property (
    lamp_test |=> ((led_red_o & led_grn_o & led_blu_o) == 8'hff))
    else $error("lamp test left an element dark");

  // Kill bit holds every digital output low
  chk_dout_muted: assert property (  // RL7
    dout_off |=> (dout_o == 8'h00))
    else $error("digital outputs not muted");

  // A read of an unmapped place returns zero
  chk_unmapped_zero: assert property (
    (bus_req && !wb_we_i && !(hit_inimg || hit_outimg || hit_colour || hit_ctrl))
    |=> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read not zero");

  cov_out_write: cover property (bus_wr && hit_outimg);
  cov_colour_read: cover property (bus_req && !wb_we_i && hit_colour);
  cov_white: cover property (red_plane[7] && grn_plane[7] && blu_plane[7]);
  cov_lamp_test: cover property (lamp_test && led_blu_o == 8'hff);

endmodule : kpm_top

`default_nettype wire

// ### tb/kpm_ctrl_model.sv
/*
  Controller model: a classic Wishbone master that moves image words.
  Assumes a slave on clk_i that answers every request with one ack.
*/
`timescale 1ns/100ps
`default_nettype none

module kpm_ctrl_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // Idle bus from time zero
  initial
  begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // One whole cycle; the request stands until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, we, a, s, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    // Released lines show the inverse, so a stale copy cannot pass
    {cyc_o, stb_o, adr_o, dat_o} <= {2'b00, ~a, ~d};
  endtask : xfer
endmodule : kpm_ctrl_model

`default_nettype wire

// ### tb/kpm_top_tb.sv
/*
  Self-checking bench of the process image block with a reference model.
  Assumes the controller model for bus cycles and pins driven by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end

module kpm_top_tb
  import kpm_pkg::*;
;
  logic clk, rst, cyc, stb, we, ack;  // Clock, reset, bus control
  logic [7:0] adr, key, line, red, grn, blu, dout;  // Address and panel pins
  logic [3:0] sel;  // Byte lanes
  logic [31:0] wdat, rdat;  // Bus data
  int fails, n_checks;  // Mismatch and comparison counts
  logic [31:0] img_m;  // Model output image
  logic [1:0] ctl_m;  // Model control
  logic [7:0] key_m, line_m;  // Model pin levels

  // Free running 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  kpm_top u_kpm_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .key_i(key), .sensed_line_bit_i(line), .led_red_o(red),
    .led_grn_o(grn), .led_blu_o(blu), .dout_o(dout));

  kpm_ctrl_model u_kpm_ctrl_model (.clk_i(clk), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // Colour of one LED from its three element bits
  function automatic logic [2:0] code_of(input logic r, input logic g, input logic b);
    case ({r, g, b})
      3'b100: code_of = KPM_COL_RED;
      3'b010: code_of = KPM_COL_GREEN;
      3'b001: code_of = KPM_COL_BLUE;
      3'b110: code_of = KPM_COL_YELLOW;
      3'b111: code_of = KPM_COL_WHITE;
      default: code_of = KPM_COL_OFF;  // Mixed blue pairs stay dark
    endcase
  endfunction : code_of

  // Element pins of colour byte c; lamp test lights everything
  function automatic logic [7:0] pin_of(input int c);
    for (int x = 0; x < 8; x++)
      pin_of[x] = ctl_m[0] | (img_m[8*c+x] &
        (code_of(img_m[x], img_m[8+x], img_m[16+x]) != KPM_COL_OFF));
  endfunction : pin_of

  // Packed colour codes, three bits per LED
  function automatic logic [31:0] col_word();
    col_word = 32'h0;
    for (int x = 0; x < 8; x++)
      col_word[3*x +: 3] = code_of(img_m[x], img_m[8+x], img_m[16+x]);
  endfunction : col_word

  // Write; the model keeps only the writable places, lane by lane
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    u_kpm_ctrl_model.xfer(1'b1, a, s, d, q);
    for (int k = 0; k < 4; k++)
      if (s[k] && a == KPM_OFS_OUTIMG) img_m[8*k +: 8] = d[8*k +: 8];
    if (s[0] && a == KPM_OFS_CTRL) ctl_m = d[1:0];
  endtask : wr

  // Read and compare with the model
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_kpm_ctrl_model.xfer(1'b0, a, 4'hf, 32'h0, q);
    `CHK($sformatf("read %h", a), e, q)
  endtask : rd

  // Every register and pin against the model
  task automatic check_all();
    rd(KPM_OFS_INIMG, {16'h0, line_m, key_m});  // Keys, lines, nothing else
    rd(KPM_OFS_OUTIMG, img_m);  // Image as written
    rd(KPM_OFS_COLOUR, col_word());  // Decoded colours
    rd(KPM_OFS_CTRL, {30'h0, ctl_m});
    rd(8'h10, 32'h0);  // Unmapped reads zero
    `CHK("red", pin_of(0), red)  // Red elements
    `CHK("green", pin_of(1), grn)  // Green elements
    `CHK("blue", pin_of(2), blu)  // Blue elements
    `CHK("dout", ctl_m[1] ? 8'h00 : img_m[31:24], dout)  // Outputs
  endtask : check_all

  // New pins, image and control; the wait covers the 3-edge input path
  task automatic step(input logic [7:0] k, input logic [7:0] l, input logic [31:0] img,
    input logic [1:0] c);
    @(posedge clk);
    key <= k;
    line <= l;
    key_m = k;
    line_m = l;
    wr(KPM_OFS_OUTIMG, 4'hf, img);
    wr(KPM_OFS_CTRL, 4'h1, {30'h0, c});
    repeat (4) @(posedge clk);
    check_all();
  endtask : step

  // Reset of design and model together
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    img_m = KPM_OUTIMG_RST;
    ctl_m = KPM_CTRL_RST;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_reset

  // Counts and verdict, then the end of the run
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  // Main sequence
  initial
  begin
    {rst, key, line, key_m, line_m} = {1'b1, 32'h0};
    {fails, n_checks} = '0;
    void'($urandom(32'hce2c8791));
    do_reset();
    check_all();
    // LED x carries combination x, so every combination appears once
    step(8'h81, 8'h3c, 32'h5af0ccaa, 2'h0);
    // Output byte lane alone; colour lanes must keep their values
    wr(KPM_OFS_OUTIMG, 4'h8, 32'h12345678);
    check_all();
    // Read-only and unmapped places drop writes
    wr(KPM_OFS_INIMG, 4'hf, 32'hffffffff);
    wr(KPM_OFS_COLOUR, 4'hf, 32'hffffffff);
    wr(8'h10, 4'hf, 32'hffffffff);
    check_all();
    // Lamp test, outputs off, both together
    for (int c = 1; c < 4; c++)
      step(8'h5a, 8'ha5, 32'hff0f3355, c[1:0]);
    // Reset in mid-run clears image and control
    do_reset();
    check_all();
    // Random pins and images
    repeat (24) step(8'($urandom), 8'($urandom), $urandom, 2'h0);
    results();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(50 * 20000);
    fails++;
    results();
  end
endmodule : kpm_top_tb

`default_nettype wire
